// ===== pkg/cal_seq_pkg.sv
// Constants shared by the calibration sequencer and its delay store
`default_nettype none
package cal_seq_pkg;
    // Sample path
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] FULL_SCALE = 8'hFF;
    localparam int LATENCY = 17;
    localparam int DEPTH = 32;
    localparam int PTR_W = 5;
    // Store word layout: {over range, core id, data}
    localparam int WORD_W = DATA_W + 2;
    localparam int CORE_BIT = DATA_W;
    localparam int OR_BIT = DATA_W + 1;
    // Read trails write by one less than the latency; the read register adds one
    localparam logic [PTR_W-1:0] RD_LAG = 5'h10;
    // Timing at the 40 MHz reference
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_MS = 1000000;
    localparam int CAL_NOM_MS = 200;
    localparam int CAL_MAX_MS = 550;
    // Nominal duration rounds down, the overdue bound is the longest wait
    localparam int CAL_NOM_CYCLES = CAL_NOM_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int CAL_MAX_CYCLES = CAL_MAX_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int CNT_W = 25;
    localparam int SYNC_N = 3;
    localparam logic [4:0] RUN_FULL = 5'h14;
    localparam logic [4:0] RUN_NEED = 5'h12;
endpackage : cal_seq_pkg
`default_nettype wire

// ===== pkg/delay_store_if.sv
// Interface joining the sequencer to its sample delay store
`timescale 1ns/100ps
`default_nettype none
interface delay_store_if;
    logic en;
    logic [cal_seq_pkg::PTR_W-1:0] wr_addr;
    logic [cal_seq_pkg::WORD_W-1:0] wr_data;
    logic [cal_seq_pkg::PTR_W-1:0] rd_addr;
    logic [cal_seq_pkg::WORD_W-1:0] rd_data;
    modport user (output en, wr_addr, wr_data, rd_addr, input rd_data);
    modport store (input en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : delay_store_if
`default_nettype wire

// ===== rtl/adc_reset_calibration_sequencer.sv
// Reset and self-calibration sequencer for a two-core interleaved converter
//
// Overview of operation
// - Each result leaves the outputs exactly 17 conversion clocks after its start.
// - The two cores are served on alternating conversion clock edges.
// - Calibration starts at the rising edge of the active-low reset line.
// - Over-range is forced high from reset line low until calibration ends.
// - Output clock pair stays low while the reset line is low.
// - Output clock resumes toggling at the next clock edge after release.
// - Calibration lasts nominally 200 ms; host waits up to 550 ms.
// - Power-on detector holds the line low until supplies pass threshold.
`timescale 1ns/100ps
`default_nettype none
module adc_reset_calibration_sequencer #(
    parameter int CAL_CYCLES = cal_seq_pkg::CAL_NOM_CYCLES
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Supply detector and reset line (open drain)
    input wire logic supply_good,
    input wire logic calibration_reset_low_in,
    output logic calibration_reset_low_out,
    output logic calibration_reset_low_oe_n,
    // Conversion samples from the cores
    input wire logic [cal_seq_pkg::DATA_W-1:0] sample_in,
    output logic core_sel,
    // Output data path
    output logic [cal_seq_pkg::DATA_W-1:0] sample_out,
    output logic sample_core,
    output logic over_range,
    output logic output_clock_pair_p,
    output logic output_clock_pair_n,
    output logic cal_busy
);
    // Counter width, named here so the size casts below can use it
    localparam int CNT_W = cal_seq_pkg::CNT_W;

    typedef struct packed {
        logic [cal_seq_pkg::SYNC_N-1:0] pin_sync;
        logic [cal_seq_pkg::SYNC_N-1:0] sup_sync;
        logic line_lvl;
        logic supply_ok;
        logic cal_busy;
        logic [cal_seq_pkg::CNT_W-1:0] cal_cnt;
        logic core_sel;
        logic clk_p;
        logic clk_n;
        logic or_force;
        logic [cal_seq_pkg::PTR_W-1:0] wr_ptr;
    } seq_s;

    seq_s r_r;
    seq_s r_nxt;
    logic line_rise;

    delay_store_if mif ();

    delay_store u_store (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .mif(mif)
    );

    // Store addressing: read trails write so the read register lands on 17
    assign mif.en = clk_en;
    assign mif.wr_addr = r_r.wr_ptr;
    assign mif.rd_addr = r_r.wr_ptr - cal_seq_pkg::RD_LAG;
    assign mif.wr_data = {(sample_in == cal_seq_pkg::FULL_SCALE),
                          r_r.core_sel, sample_in};

    // Level filter releases a rise once stages two and three agree
    assign line_rise = !r_r.line_lvl && r_r.pin_sync[1] && r_r.pin_sync[2];

    // Next-state logic; all state frozen while the enable is low
    always_comb begin
        r_nxt = r_r;
        if (clk_en) begin
            r_nxt.pin_sync = {r_r.pin_sync[1:0], calibration_reset_low_in};
            r_nxt.sup_sync = {r_r.sup_sync[1:0], supply_good};
            // A low at stage two counts at once, so a one-cycle request is
            // never filtered away; a rise still waits for two and three
            if (!r_r.pin_sync[1] || r_r.pin_sync[1] == r_r.pin_sync[2]) begin
                r_nxt.line_lvl = r_r.pin_sync[1];
            end
            if (r_r.sup_sync[1] == r_r.sup_sync[2]) begin
                r_nxt.supply_ok = r_r.sup_sync[2];
            end
            r_nxt.core_sel = !r_r.core_sel;
            r_nxt.wr_ptr = r_r.wr_ptr + 1'b1;
            // Rise tested first: the filtered level is still low then
            // A new low restarts calibration from scratch
            if (line_rise) begin
                r_nxt.cal_busy = 1'b1;
                r_nxt.cal_cnt = '0;
            end else if (!r_r.line_lvl) begin
                r_nxt.cal_busy = 1'b0;
                r_nxt.cal_cnt = '0;
            end else if (r_r.cal_busy) begin
                if (r_r.cal_cnt >= CNT_W'(CAL_CYCLES - 1)) begin
                    r_nxt.cal_busy = 1'b0;
                end else begin
                    r_nxt.cal_cnt = r_r.cal_cnt + 1'b1;
                end
            end
            // Force over-range from the low until the count finishes
            r_nxt.or_force = !r_nxt.line_lvl || r_nxt.cal_busy;
            // Output clock parked low while line low, toggles once released
            if (!r_nxt.line_lvl) begin
                r_nxt.clk_p = 1'b0;
                r_nxt.clk_n = 1'b0;
            end else begin
                r_nxt.clk_p = !r_r.clk_p;
                r_nxt.clk_n = r_r.clk_p;
            end
        end
    end

    // Line starts low at power-on, so the first release is a rising edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r_r <= '0;
            r_r.or_force <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Power-on hold: drive the line low until supplies are good
    assign calibration_reset_low_out = 1'b0;
    assign calibration_reset_low_oe_n = r_r.supply_ok;

    // Outputs; over-range passes the sample flag once calibration ends
    assign sample_out = mif.rd_data[cal_seq_pkg::DATA_W-1:0];
    assign sample_core = mif.rd_data[cal_seq_pkg::CORE_BIT];
    assign over_range = r_r.or_force
                        || mif.rd_data[cal_seq_pkg::OR_BIT];
    assign output_clock_pair_p = r_r.clk_p;
    assign output_clock_pair_n = !r_r.clk_p && r_r.line_lvl && r_r.clk_n;
    assign core_sel = r_r.core_sel;
    assign cal_busy = r_r.cal_busy;

    // Helper: count of consecutive enabled cycles, saturating
    logic [4:0] run_r;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            run_r <= '0;
        end else if (!clk_en) begin
            run_r <= '0;
        end else if (run_r != cal_seq_pkg::RUN_FULL) begin
            run_r <= run_r + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence line_low_seen;
        clk_en && !r_r.pin_sync[1];
    endsequence

    sequence released_edge;
        clk_en && line_rise;
    endsequence

    chk_latency_fixed: assert property (
        run_r >= cal_seq_pkg::RUN_NEED |->
            sample_out == $past(sample_in, cal_seq_pkg::LATENCY))
        else $error("sample latency is not 17 cycles");

    chk_core_alternate: assert property (
        clk_en ##1 clk_en |-> core_sel != $past(core_sel))
        else $error("core select did not alternate");

    chk_cal_start: assert property (
        released_edge |=> cal_busy && r_r.cal_cnt == '0)
        else $error("calibration did not start on release");

    chk_or_forced: assert property (
        (!r_r.line_lvl || cal_busy) |-> over_range)
        else $error("over range not forced during calibration");

    chk_clock_parked: assert property (
        !r_r.line_lvl |-> !output_clock_pair_p && !output_clock_pair_n)
        else $error("output clock not low while line low");

    chk_clock_resume: assert property (
        released_edge |=> output_clock_pair_p ##1 (!clk_en ||
            !output_clock_pair_p))
        else $error("output clock did not resume");

    chk_cal_bounded: assert property (
        cal_busy |-> r_r.cal_cnt < CNT_W'(CAL_CYCLES))
        else $error("calibration count overran");

    chk_cal_ends: assert property (
        cal_busy && clk_en && r_r.line_lvl &&
            r_r.cal_cnt == CNT_W'(CAL_CYCLES - 1) |=> !cal_busy)
        else $error("calibration ran past its length");

    chk_por_hold: assert property (
        !r_r.supply_ok |-> !calibration_reset_low_oe_n &&
            !calibration_reset_low_out)
        else $error("line not held low before supplies good");

    chk_pulse_caught: assert property (
        line_low_seen |=> !r_r.line_lvl)
        else $error("low pulse on reset line was missed");
endmodule : adc_reset_calibration_sequencer
`default_nettype wire

// ===== rtl/delay_store.sv
// Small circular store holding samples for the fixed pipeline delay
`timescale 1ns/100ps
`default_nettype none
module delay_store (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Store port
    delay_store_if.store mif
);
    typedef struct packed {
        logic [cal_seq_pkg::DEPTH-1:0][cal_seq_pkg::WORD_W-1:0] mem;
        logic [cal_seq_pkg::WORD_W-1:0] rd_data;
    } store_s;

    store_s st_r;
    store_s st_nxt;

    // Write one word and read another each enabled cycle
    always_comb begin
        st_nxt = st_r;
        if (mif.en) begin
            st_nxt.mem[mif.wr_addr] = mif.wr_data;
            st_nxt.rd_data = st_r.mem[mif.rd_addr];
        end
    end

    // Clearing the store avoids stray over-range after reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mif.rd_data = st_r.rd_data;
endmodule : delay_store
`default_nettype wire

// ===== verif/adc_reset_calibration_sequencer_tb.sv
// Self-checking bench for the calibration sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_reset_calibration_sequencer_tb;
    localparam int CAL_N = 50;
    logic ref_clk, nrst, supply_good, req, host_oe_n;
    logic [7:0] sample_in, plen, sample_out;
    logic [7:0] hist [64];
    logic hcore [64];
    logic dev_out, dev_oe_n, core_sel, sample_core, over_range;
    logic clk_p, clk_n, cal_busy, pp, clk_en;
    wire line_lvl;
    int seed, errors, check_count, t, cycles;
    // Pull-up wins unless a party pulls low
    assign line_lvl = (dev_oe_n | dev_out) & host_oe_n;
    adc_reset_calibration_sequencer #(.CAL_CYCLES(CAL_N)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
        .supply_good(supply_good), .calibration_reset_low_in(line_lvl),
        .calibration_reset_low_out(dev_out),
        .calibration_reset_low_oe_n(dev_oe_n),
        .sample_in(sample_in), .core_sel(core_sel),
        .sample_out(sample_out), .sample_core(sample_core),
        .over_range(over_range), .output_clock_pair_p(clk_p),
        .output_clock_pair_n(clk_n), .cal_busy(cal_busy)
    );
    host_model host (
        .ref_clk(ref_clk), .req(req), .pulse_len(plen),
        .pull_oe_n(host_oe_n)
    );
    // Free-running conversion clock
    always #12.5 ref_clk = ~ref_clk;
    // Hang guard, well above the expected few hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic exp_or(input logic [7:0] s);
        return s == cal_seq_pkg::FULL_SCALE;
    endfunction : exp_or
    // Full-scale and zero corners among random codes
    function automatic logic [7:0] pick(input int i);
        case (i % 4)
            0: return 8'hFF;
            1: return 8'h00;
            default: return 8'($random(seed));
        endcase
    endfunction : pick
    // Inside full scale so the end of calibration shows
    function automatic logic [7:0] safe();
        return 8'($random(seed)) & 8'h7F;
    endfunction : safe
    // Check settled outputs at the falling edge, then drive the next code
    task automatic step(input logic [7:0] v, input logic on);
        int k;
        @(negedge ref_clk);
        k = (t - 17) & 63;
        if (on) begin
            chk(sample_out, hist[k]);
            chk(over_range, exp_or(hist[k]));
            chk(sample_core, hcore[k]);
            chk(core_sel, !hcore[(t - 1) & 63]);
        end
        sample_in = v;
        hist[t & 63] = v;
        hcore[t & 63] = core_sel;
        t++;
    endtask : step
    // Wait for calibration, then time it and watch the outputs
    task automatic cal_run();
        int n;
        n = 0;
        while (cal_busy !== 1'b1 && n < 12) begin
            step(safe(), 1'b0);
            n++;
        end
        chk(cal_busy, 8'h01);
        n = 0;
        while (cal_busy === 1'b1 && n < 200) begin
            chk(over_range, 8'h01);
            chk(clk_n, !clk_p);
            if (n > 0) chk(clk_p, !pp);
            pp = clk_p;
            step(safe(), 1'b0);
            n++;
        end
        chk(8'(n), 8'(CAL_N));
    endtask : cal_run
    task automatic data_run(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            step(pick(i), 1'b1);
            if (i == 20) freeze(3);
        end
    endtask : data_run
    // Enable low for a few cycles: the pipeline must hold still
    task automatic freeze(input int n);
        logic [7:0] held;
        logic hc;
        clk_en = 1'b0;
        held = sample_out;
        hc = core_sel;
        repeat (n) begin
            @(negedge ref_clk);
            chk(sample_out, held);
            chk(core_sel, hc);
        end
        clk_en = 1'b1;
    endtask : freeze
    // Host pulse on the reset line, then the full recalibration
    task automatic recal(input logic [7:0] len);
        plen = len;
        req = 1'b1;
        step(safe(), 1'b0);
        req = 1'b0;
        repeat (4) step(safe(), 1'b0);
        chk(clk_p, 8'h00);
        chk(clk_n, 8'h00);
        chk(over_range, 8'h01);
        cal_run();
        data_run(40);
    endtask : recal
    task automatic close_out();
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // Main sequence: power-on, data, host recalibration, data
    initial begin
        seed = 3423;
        ref_clk = 1'b0;
        nrst = 1'b0;
        supply_good = 1'b0;
        sample_in = 8'h00;
        req = 1'b0;
        clk_en = 1'b1;
        plen = 8'h03;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) nrst = 1'b1;
        repeat (8) step(safe(), 1'b0);
        chk(dev_oe_n, 8'h00);
        chk(clk_p, 8'h00);
        chk(over_range, 8'h01);
        chk(cal_busy, 8'h00);
        supply_good = 1'b1;
        cal_run();
        chk(dev_oe_n, 8'h01);
        data_run(40);
        // Random pulse length, then the one-cycle corner
        recal(8'h03 + (8'($random(seed)) & 8'h03));
        recal(8'h01);
        close_out();
    end
endmodule : adc_reset_calibration_sequencer_tb
`default_nettype wire

// ===== verif/host_model.sv
// Host model that pulls the open-drain calibration reset line
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock
    input wire logic ref_clk,
    // Request and low pulse length in cycles
    input wire logic req,
    input wire logic [7:0] pulse_len,
    // Open-drain drive, low while pulling
    output logic pull_oe_n
);
    logic [7:0] left = 8'h00;
    // Whole-cycle low pulse of pulse_len cycles
    always @(posedge ref_clk) begin
        if (left != 8'h00) begin
            left <= left - 8'h01;
        end else if (req) begin
            left <= pulse_len;
        end
    end
    // Pulls only while cycles remain; otherwise the pull-up wins
    assign pull_oe_n = (left == 8'h00);
endmodule : host_model
`default_nettype wire
